//--- timer_pkg.sv
package timer_pkg;

  // ==========================================================
  // Register addresses and reset values
  localparam logic [7:0] ADDR_RUN_CONTROL = 8'h88;
  localparam logic [7:0] ADDR_MODE_CONFIG = 8'h89;
  localparam logic [7:0] ADDR_LOW_ZERO = 8'h8A;
  localparam logic [7:0] ADDR_LOW_ONE = 8'h8B;
  localparam logic [7:0] ADDR_HIGH_ZERO = 8'h8C;
  localparam logic [7:0] ADDR_HIGH_ONE = 8'h8D;
  localparam logic [7:0] MODE_CONFIG_RESET = 8'h00;
  localparam logic [7:0] RUN_CONTROL_RESET = 8'h00;

  // ==========================================================
  // Field positions
  localparam int RUN_CTRL_OVF_ONE = 7;
  localparam int RUN_CTRL_RUN_ONE = 6;
  localparam int RUN_CTRL_OVF_ZERO = 5;
  localparam int RUN_CTRL_RUN_ZERO = 4;
  localparam int MODE_NIBBLE_ONE = 4;
  localparam int MODE_NIBBLE_ZERO = 0;
  localparam int CFG_GATE = 3;
  localparam int CFG_COUNT_SEL = 2;

  // ==========================================================
  // Timing
  localparam int CLOCKS_PER_MACHINE_CYCLE = 12;
  localparam int PRESCALE_BITS = 5;

  // ==========================================================
  // Modes and carriers
  typedef enum logic [1:0] {
    MODE_13BIT = 2'b00,
    MODE_16BIT = 2'b01,
    MODE_RELOAD = 2'b10,
    MODE_SPLIT = 2'b11
  } timer_mode_e;

  typedef struct packed {
    logic gate_enable;
    logic count_select;
    timer_mode_e mode;
  } timer_cfg_s;

  typedef struct packed {
    logic [7:0] high_byte;
    logic [7:0] low_byte;
  } timer_count_s;

endpackage

//--- timer_channel.sv
`timescale 1ns/1ps

module timer_channel
  import timer_pkg::*;
(
  // Configuration and gating
  input wire timer_cfg_s cfg,
  input wire logic run,
  input wire logic gate_level,
  input wire logic machine_tick,
  input wire logic edge_seen,
  input wire logic hold,
  // Current count
  input wire timer_count_s count_q,
  // Next count and overflow
  output timer_count_s count_next,
  output logic overflow
);

  logic step;
  logic [PRESCALE_BITS:0] pre_sum;
  logic [8:0] low_sum;
  logic [8:0] high_sum;

  // ==========================================================
  // Enable and step
  always_comb begin
    step = run && (!cfg.gate_enable || gate_level) && !hold &&
      (cfg.count_select ? edge_seen : machine_tick);
    pre_sum = {1'b0, count_q.low_byte[PRESCALE_BITS-1:0]} + 6'h01;
    low_sum = {1'b0, count_q.low_byte} + 9'h001;
    high_sum = {1'b0, count_q.high_byte} + 9'h001;
    count_next = count_q;
    overflow = 1'b0;
    if (step) begin
      unique case (cfg.mode)
        MODE_13BIT: begin
          // Upper low-byte bits are left as they stand: no defined value
          count_next.low_byte[PRESCALE_BITS-1:0] =
            pre_sum[PRESCALE_BITS-1:0];
          if (pre_sum[PRESCALE_BITS]) begin
            count_next.high_byte = high_sum[7:0];
            overflow = high_sum[8];
          end
        end
        MODE_16BIT: begin
          count_next.low_byte = low_sum[7:0];
          if (low_sum[8]) begin
            count_next.high_byte = high_sum[7:0];
            overflow = high_sum[8];
          end
        end
        MODE_RELOAD: begin
          if (low_sum[8]) begin
            count_next.low_byte = count_q.high_byte;
            overflow = 1'b1;
          end else begin
            count_next.low_byte = low_sum[7:0];
          end
        end
        MODE_SPLIT: begin
          // Low byte alone; the parent handles the high byte
          count_next.low_byte = low_sum[7:0];
          overflow = low_sum[8];
        end
      endcase
    end
  end

endmodule

//--- dual_timer_counter.sv
`timescale 1ns/1ps

// What this block does
// - Two independent 16-bit timer/counters
// - Timer function counts every 12 clocks
// - Counter function counts input falling edges
// - Edge detection takes two machine cycles
// - Run bit starts and stops timer
// - Mode register: timer 1 high nibble
// - Gate enable requires input high to count
// - Select bit: 1 counts edges, 0 timing
// - Mode bits pick 13, 16, 8-reload
// - Timer 1 mode 3 holds its count
// - Timer 0 mode 3 splits into bytes
// - 13-bit mode: 5-bit prescaler under high
// - 13-bit mode upper low bits undefined
// - Wrap to zero sets overflow flag
// - Overflow flag serves as interrupt request
// - 13-bit enable: run and gate condition
// - Setting run bit keeps count bytes
// - Mode register at 0x89, resets zero
// - 16-bit mode uses all sixteen bits
// - Reload mode reloads low from high
// - Split high byte uses timer 1 controls
// - Flags cleared by software or service

module dual_timer_counter
  import timer_pkg::*;
#(
  parameter int DIVIDE = CLOCKS_PER_MACHINE_CYCLE
)(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Special function register port
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_write,
  input wire logic sfr_read,
  output logic [7:0] sfr_rdata,
  // External count and gate pins
  input wire logic count_input_zero,
  input wire logic count_input_one,
  // Interrupt requests and service acknowledges
  output logic timer_irq_zero,
  output logic timer_irq_one,
  input wire logic irq_ack_zero,
  input wire logic irq_ack_one,
  // Machine-cycle strobe for other blocks
  output logic machine_cycle
);

  // Refused at elaboration: the divider register is eight bits wide
  if (DIVIDE < 2 || DIVIDE > 255) begin : g_bad_divide
    $error("DIVIDE out of range");
  end

  // ==========================================================
  // Machine-cycle divider
  logic [7:0] div_q, div_d;
  logic tick;

  always_comb begin
    tick = (div_q == 8'(DIVIDE - 1));
    div_d = tick ? 8'h00 : div_q + 8'h01;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_d;
    end
  end

  assign machine_cycle = tick;

  // ==========================================================
  // Pin synchronisers and once-per-machine-cycle sampling
  // Pins cross two flops first; the sample register is read only
  // at machine-cycle boundaries, so an edge costs two machine cycles.
  logic [1:0] pin_meta_q, pin_sync_q;
  logic [1:0] samp_q, samp_d, prev_q, prev_d;
  logic [1:0] fell;

  always_ff @(posedge mclk) begin
    if (reset) begin
      pin_meta_q <= 2'b00;
      pin_sync_q <= 2'b00;
    end else begin
      pin_meta_q <= {count_input_one, count_input_zero};
      pin_sync_q <= pin_meta_q;
    end
  end

  always_comb begin
    samp_d = tick ? pin_sync_q : samp_q;
    prev_d = tick ? samp_q : prev_q;
    fell = prev_q & ~samp_q & {2{tick}};
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      samp_q <= 2'b00;
      prev_q <= 2'b00;
    end else begin
      samp_q <= samp_d;
      prev_q <= prev_d;
    end
  end

  // ==========================================================
  // Registers
  logic [7:0] mode_cfg_q, mode_cfg_d;
  logic run_zero_q, run_zero_d, run_one_q, run_one_d;
  logic ovf_zero_q, ovf_zero_d, ovf_one_q, ovf_one_d;
  timer_count_s cnt0_q, cnt0_d, cnt1_q, cnt1_d;
  timer_count_s next0, next1;
  timer_cfg_s cfg0, cfg1;
  logic ovf0, ovf1, split, hold1;
  logic [8:0] split_sum;
  logic split_step, split_ovf;

  always_comb begin
    cfg0 = timer_cfg_s'(mode_cfg_q[MODE_NIBBLE_ZERO +: 4]);
    cfg1 = timer_cfg_s'(mode_cfg_q[MODE_NIBBLE_ONE +: 4]);
    split = (cfg0.mode == MODE_SPLIT);
    hold1 = (cfg1.mode == MODE_SPLIT);
  end

  timer_channel u_chan0 (
    .cfg(cfg0),
    .run(run_zero_q),
    .gate_level(samp_q[0]),
    .machine_tick(tick),
    .edge_seen(fell[0]),
    .hold(1'b0),
    .count_q(cnt0_q),
    .count_next(next0),
    .overflow(ovf0)
  );

  timer_channel u_chan1 (
    .cfg(cfg1),
    .run(run_one_q),
    .gate_level(samp_q[1]),
    .machine_tick(tick),
    .edge_seen(fell[1]),
    .hold(hold1),
    .count_q(cnt1_q),
    .count_next(next1),
    .overflow(ovf1)
  );

  always_comb begin
    // Split high byte counts machine cycles under timer 1's run bit
    split_step = split && run_one_q && tick;
    split_sum = {1'b0, cnt0_q.high_byte} + 9'h001;
    split_ovf = split_step && split_sum[8];
    cnt0_d = next0;
    if (split) begin
      cnt0_d.high_byte = split_step ? split_sum[7:0] : cnt0_q.high_byte;
    end
    cnt1_d = next1;
    mode_cfg_d = mode_cfg_q;
    run_zero_d = run_zero_q;
    run_one_d = run_one_q;
    ovf_zero_d = ovf_zero_q && !irq_ack_zero;
    // Timer 1 still counts in split mode but its flag is lent out
    ovf_one_d = ovf_one_q && !irq_ack_one;
    if (sfr_write) begin
      unique case (sfr_addr)
        ADDR_MODE_CONFIG: mode_cfg_d = sfr_wdata;
        ADDR_RUN_CONTROL: begin
          run_one_d = sfr_wdata[RUN_CTRL_RUN_ONE];
          run_zero_d = sfr_wdata[RUN_CTRL_RUN_ZERO];
          ovf_one_d = sfr_wdata[RUN_CTRL_OVF_ONE];
          ovf_zero_d = sfr_wdata[RUN_CTRL_OVF_ZERO];
        end
        ADDR_LOW_ZERO: cnt0_d.low_byte = sfr_wdata;
        ADDR_HIGH_ZERO: cnt0_d.high_byte = sfr_wdata;
        ADDR_LOW_ONE: cnt1_d.low_byte = sfr_wdata;
        ADDR_HIGH_ONE: cnt1_d.high_byte = sfr_wdata;
        default: ;
      endcase
    end
    // Hardware set wins over a software or service clear
    if (ovf0) begin
      ovf_zero_d = 1'b1;
    end
    if (split ? split_ovf : ovf1) begin
      ovf_one_d = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      mode_cfg_q <= MODE_CONFIG_RESET;
      run_zero_q <= RUN_CONTROL_RESET[RUN_CTRL_RUN_ZERO];
      run_one_q <= RUN_CONTROL_RESET[RUN_CTRL_RUN_ONE];
      ovf_zero_q <= RUN_CONTROL_RESET[RUN_CTRL_OVF_ZERO];
      ovf_one_q <= RUN_CONTROL_RESET[RUN_CTRL_OVF_ONE];
      cnt0_q <= '0;
      cnt1_q <= '0;
    end else begin
      mode_cfg_q <= mode_cfg_d;
      run_zero_q <= run_zero_d;
      run_one_q <= run_one_d;
      ovf_zero_q <= ovf_zero_d;
      ovf_one_q <= ovf_one_d;
      cnt0_q <= cnt0_d;
      cnt1_q <= cnt1_d;
    end
  end

  // ==========================================================
  // Read-back and interrupt requests
  always_ff @(posedge mclk) begin
    if (reset) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_read) begin
      unique case (sfr_addr)
        ADDR_MODE_CONFIG: sfr_rdata <= mode_cfg_q;
        ADDR_RUN_CONTROL:
          sfr_rdata <= {ovf_one_q, run_one_q, ovf_zero_q, run_zero_q, 4'h0};
        ADDR_LOW_ZERO: sfr_rdata <= cnt0_q.low_byte;
        ADDR_HIGH_ZERO: sfr_rdata <= cnt0_q.high_byte;
        ADDR_LOW_ONE: sfr_rdata <= cnt1_q.low_byte;
        ADDR_HIGH_ONE: sfr_rdata <= cnt1_q.high_byte;
        default: sfr_rdata <= 8'h00;
      endcase
    end
  end

  assign timer_irq_zero = ovf_zero_q;
  assign timer_irq_one = ovf_one_q;

endmodule

//--- dual_timer_counter_props.sv
`timescale 1ns/1ps
// ==========================================================
// Port checker
module dual_timer_counter_props
  import timer_pkg::*;
#(
  parameter int DIVIDE = 12
)(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_write,
  input wire logic sfr_read,
  input wire logic [7:0] sfr_rdata,
  // Pins, requests and strobe
  input wire logic count_input_zero,
  input wire logic count_input_one,
  input wire logic timer_irq_zero,
  input wire logic timer_irq_one,
  input wire logic irq_ack_zero,
  input wire logic irq_ack_one,
  input wire logic machine_cycle
);
  logic [7:0] cnt_q, cnt_d;
  logic seen_q, seen_d;
  logic ctl_wr;
  assign ctl_wr = sfr_write && sfr_addr == ADDR_RUN_CONTROL;
  // Tick spacing is only known after the first tick
  always_comb begin
    cnt_d = machine_cycle ? 8'h00 : cnt_q + 8'h01;
    seen_d = seen_q | machine_cycle;
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      cnt_q <= 8'h00;
      seen_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      seen_q <= seen_d;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  a_tick_spacing: assert property (machine_cycle && seen_q |->
    cnt_q == DIVIDE - 1) else $error("tick spacing off");
  a_tick_single: assert property (machine_cycle |=> !machine_cycle)
    else $error("tick longer than one clock");
  a_mode_readback: assert property (sfr_write &&
    sfr_addr == ADDR_MODE_CONFIG ##1 !sfr_write ##1 sfr_read &&
    !sfr_write && sfr_addr == ADDR_MODE_CONFIG |=>
    sfr_rdata == $past(sfr_wdata, 3))
    else $error("mode register readback differs");
  a_unmapped_zero: assert property (sfr_read && (sfr_addr < 8'h88 ||
    sfr_addr > 8'h8d) |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (!sfr_read |=> $stable(sfr_rdata))
    else $error("read data moved without a read");
  a_ack_clears_zero: assert property (irq_ack_zero &&
    !machine_cycle && !ctl_wr |=> !timer_irq_zero)
    else $error("ack did not clear flag zero");
  a_ack_clears_one: assert property (irq_ack_one &&
    !machine_cycle && !ctl_wr |=> !timer_irq_one)
    else $error("ack did not clear flag one");
  a_flag_sticky: assert property (timer_irq_zero &&
    !irq_ack_zero && !ctl_wr |=> timer_irq_zero)
    else $error("flag zero dropped by itself");
  a_flag_cause: assert property ($rose(timer_irq_one) |->
    $past(machine_cycle) || $past(ctl_wr))
    else $error("flag one rose without cause");
  a_flag_write: assert property (ctl_wr &&
    sfr_wdata[RUN_CTRL_OVF_ONE] |=> timer_irq_one)
    else $error("software set of flag one lost");
endmodule

//--- count_pin_model.sv
`timescale 1ns/1ps
// ==========================================================
// External count and gate source
module count_pin_model (
  // Clock
  input wire logic mclk,
  // Command
  input wire logic start,
  input wire logic idle_level,
  input wire logic [7:0] edges,
  input wire logic [7:0] hold_clocks,
  // Pin and status
  output logic pin,
  output logic busy
);
  initial begin
    pin = 1'b1;
    busy = 1'b0;
    forever begin
      @(posedge mclk);
      if (start) begin
        busy <= 1'b1;
        // Each level held a full machine cycle plus margin
        repeat (edges) begin
          pin <= 1'b1;
          repeat (hold_clocks) @(posedge mclk);
          pin <= 1'b0;
          repeat (hold_clocks) @(posedge mclk);
        end
        busy <= 1'b0;
      end else begin
        pin <= idle_level;
      end
    end
  end
endmodule

//--- dual_timer_counter_tb.sv
`timescale 1ns/1ps
// ==========================================================
// Bench
module dual_timer_counter_tb;
  import timer_pkg::*;
  localparam int DIVIDE = 12;
  logic mclk = 0, reset = 1, sfr_write = 0, sfr_read = 0;
  logic [7:0] sfr_addr = 0, sfr_wdata = 0, sfr_rdata, edges = 0, hold = 0;
  logic ack0 = 0, ack1 = 0, start0 = 0, start1 = 0, idle0 = 1, idle1 = 0;
  logic pin0, pin1, busy0, timer_irq_zero, timer_irq_one, machine_cycle;
  int fail_count = 0, checks = 0;
  dual_timer_counter #(.DIVIDE(DIVIDE)) DUT (.mclk(mclk), .reset(reset),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_write(sfr_write),
    .sfr_read(sfr_read), .sfr_rdata(sfr_rdata), .count_input_zero(pin0),
    .count_input_one(pin1), .timer_irq_zero(timer_irq_zero),
    .timer_irq_one(timer_irq_one), .irq_ack_zero(ack0),
    .irq_ack_one(ack1), .machine_cycle(machine_cycle));
  count_pin_model src0 (.mclk(mclk), .start(start0), .idle_level(idle0),
    .edges(edges), .hold_clocks(hold), .pin(pin0), .busy(busy0));
  count_pin_model src1 (.mclk(mclk), .start(start1), .idle_level(idle1),
    .edges(edges), .hold_clocks(hold), .pin(pin1), .busy());
  initial begin
    forever #20 mclk = ~mclk;
  end
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_write <= 1'b1;
    @(posedge mclk);
    sfr_write <= 1'b0;
    // Idle edge so a following write never re-raises in this step
    @(posedge mclk);
  endtask
  // Data is taken one edge late: it stands until the next read
  task automatic rd(logic [7:0] a, output logic [7:0] d);
    sfr_addr <= a;
    sfr_read <= 1'b1;
    @(posedge mclk);
    sfr_read <= 1'b0;
    @(posedge mclk);
    d = sfr_rdata;
  endtask
  task automatic tick(int n);
    int g;
    repeat (n) begin
      g = 0;
      do begin
        @(posedge mclk);
        g++;
      end while (machine_cycle !== 1'b1 && g < 100);
      if (g >= 100) begin
        fail_count++;
        finish_test();
      end
    end
  endtask
  task automatic mode_test(int t, int m);
    int hi, lo, c, f, g;
    logic [7:0] v;
    hi = (m == 2) ? $urandom % 256 : 255;
    lo = 248 + $urandom % 8;
    f = 0;
    g = 0;
    wr(ADDR_RUN_CONTROL, 8'h00);
    wr(ADDR_MODE_CONFIG, 8'(m << (4 * t)));
    wr(t ? ADDR_LOW_ONE : ADDR_LOW_ZERO, 8'(lo));
    wr(t ? ADDR_HIGH_ONE : ADDR_HIGH_ZERO, 8'(hi));
    tick(1);
    wr(ADDR_RUN_CONTROL, t ? 8'h40 : (m == 3 ? 8'h50 : 8'h10));
    for (int i = 0; i < 10; i++) begin
      case (m)
        0: begin
          c = hi * 32 + lo % 32 + 1;
          f |= c >> 13;
          hi = (c >> 5) % 256;
          lo = lo / 32 * 32 + c % 32;
        end
        1: begin
          c = hi * 256 + lo + 1;
          f |= c >> 16;
          hi = (c >> 8) % 256;
          lo = c % 256;
        end
        default: if (t == 0 || m == 2) begin
          lo++;
          if (lo == 256) begin
            f = 1;
            lo = (m == 2) ? hi : 0;
          end
          if (m == 3) begin
            hi = (hi + 1) % 256;
            g |= (hi == 0);
          end
        end
      endcase
    end
    tick(10);
    check("flag zero", 16'(timer_irq_zero), 16'(t ? 0 : f));
    check("flag one", 16'(timer_irq_one), 16'(t ? f : g));
    wr(ADDR_RUN_CONTROL, t ? 8'(f << 7) : 8'((f << 5) | (g << 7)));
    tick(2);
    rd(t ? ADDR_LOW_ONE : ADDR_LOW_ZERO, v);
    check("low byte", 16'(v), 16'(lo));
    rd(t ? ADDR_HIGH_ONE : ADDR_HIGH_ZERO, v);
    check("high byte", 16'(v), 16'(hi));
    ack0 <= 1'b1;
    ack1 <= 1'b1;
    @(posedge mclk);
    ack0 <= 1'b0;
    ack1 <= 1'b0;
    @(posedge mclk);
    check("acked flags", 16'({timer_irq_one, timer_irq_zero}), 16'h0000);
    $display("test mode %0d timer %0d done", m, t);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    logic [7:0] v, r;
    int n, g;
    v = 8'($urandom(32'h0000_b8a8));
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      rd(i == 0 ? ADDR_MODE_CONFIG : (i == 1 ? ADDR_RUN_CONTROL : 8'h90), v);
      check("reset or unmapped", 16'(v), 16'h0000);
    end
    repeat (4) begin
      r = 8'($urandom);
      wr(ADDR_MODE_CONFIG, r);
      rd(ADDR_MODE_CONFIG, v);
      check("mode register", 16'(v), 16'(r));
    end
    $display("test registers done");
    for (int t = 0; t < 2; t++) begin
      for (int m = 0; m < 4; m++) begin
        mode_test(t, m);
      end
    end
    n = 3 + $urandom % 6;
    wr(ADDR_MODE_CONFIG, 8'h95);
    for (int i = 0; i < 4; i++) begin
      wr(8'h8a + 8'(i), 8'h00);
    end
    wr(ADDR_RUN_CONTROL, 8'h50);
    edges <= 8'(n);
    hold <= 8'(DIVIDE + 4);
    start0 <= 1'b1;
    @(posedge mclk);
    start0 <= 1'b0;
    g = 0;
    do begin
      @(posedge mclk);
      g++;
    end while (busy0 !== 1'b0 && g < 1000);
    if (g >= 1000) begin
      fail_count++;
      finish_test();
    end
    tick(3);
    wr(ADDR_RUN_CONTROL, 8'h00);
    rd(ADDR_LOW_ZERO, v);
    check("edge count", 16'(v), 16'(n));
    rd(ADDR_LOW_ONE, v);
    check("gated low", 16'(v), 16'h0000);
    idle1 <= 1'b1;
    tick(3);
    wr(ADDR_RUN_CONTROL, 8'h40);
    tick(8);
    wr(ADDR_RUN_CONTROL, 8'h00);
    rd(ADDR_LOW_ONE, v);
    check("gated high", 16'(v), 16'h0008);
    $display("test counter and gate done");
    finish_test();
  end
endmodule

bind dual_timer_counter dual_timer_counter_props #(.DIVIDE(DIVIDE)) u_props (
  .mclk(mclk), .reset(reset), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
  .sfr_write(sfr_write), .sfr_read(sfr_read), .sfr_rdata(sfr_rdata),
  .count_input_zero(count_input_zero), .count_input_one(count_input_one),
  .timer_irq_zero(timer_irq_zero), .timer_irq_one(timer_irq_one),
  .irq_ack_zero(irq_ack_zero), .irq_ack_one(irq_ack_one),
  .machine_cycle(machine_cycle));
